// File: vsc_defs.svh
// Timing constants and command-byte field positions for the voice store serial control.
// Assumes the system clock runs at 125 MHz.
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

`define VSC_CLK_HZ 125000000
`define VSC_WAKE_DELAY_MS 25
`define VSC_WAKE_CYCLES ((`VSC_CLK_HZ / 1000) * `VSC_WAKE_DELAY_MS)
`define VSC_FRAME_BITS 24
`define VSC_CTRL_BITS 8
`define VSC_ADDR_BITS 16
`define VSC_BIT_GO 7
`define VSC_BIT_DIR 6
`define VSC_BIT_POWER 5
`define VSC_BIT_IGNADDR 4
`define VSC_BIT_CUE 3
`define VSC_LAST_ROW 16'h095F
`define VSC_STEP_CYCLES 32'h0000_0040

`endif

// File: vsc_pkg.sv
// Types shared by the voice store serial control block.
// Assumes nothing beyond a SystemVerilog compiler.
package vsc_pkg;
    typedef enum logic [1:0] {
        VSC_IDLE = 2'b00,
        VSC_PLAY = 2'b01,
        VSC_REC = 2'b10
    } vsc_op_t;
endpackage

// File: vsc_sync3.sv
// Three-stage synchroniser whose output changes once stages two and three agree.
// Assumes the input is asynchronous to clk_sys.
module vsc_sync3 (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Signal
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dout <= 1'b1;
        end else if (s2 == s3) begin
            dout <= s3;
        end
    end
endmodule

// File: vsc_shifter.sv
// Serial frame shifter: samples data on rising link-clock edges, moves output on falling edges.
// Assumes edge strobes are one-cycle pulses derived from a synchronised link clock.
module vsc_shifter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link events
    input wire logic frame_start,
    input wire logic rise,
    input wire logic fall,
    input wire logic mosi_bit,
    // Status to send, captured at frame start
    input wire logic [23:0] load_word,
    // Results
    output logic [23:0] rx_word,
    output logic [4:0] rx_count,
    output logic miso_bit
);
    logic [23:0] tx_word;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_word <= 24'h00_0000;
            rx_count <= 5'h00;
        end else if (frame_start) begin
            rx_count <= 5'h00;
        end else if (rise && rx_count != 5'h1F) begin
            rx_word <= {rx_word[22:0], mosi_bit};
            rx_count <= rx_count + 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_word <= 24'h00_0000;
            miso_bit <= 1'b0;
        end else if (frame_start) begin
            tx_word <= {load_word[22:0], 1'b0};
            miso_bit <= load_word[23];
        end else if (fall) begin
            tx_word <= {tx_word[22:0], 1'b0};
            miso_bit <= tx_word[23];
        end
    end
endmodule

// File: vsc_core.sv
// Command interpreter of a serial voice record and playback store.
// Assumes the host is a serial master with idle-low clock, select active low.
`include "vsc_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Cueing is latched only when a playback begins, ignored mid-operation.
// - Status shifts out on the output while a command shifts in.
// - After power-on the device is ready only after the wake delay.
// - Playback runs from the address, flags end of message and halts.
// - Recording runs to memory end, flags overflow and halts.
// - Go bit one starts the selected operation, zero stops it.
// - Direction bit one selects playback, zero recording.
// - Cue bit one enables fast message cueing, zero disables it.
// - Power bit one powers up, zero enters standby only when the go bit is also zero.
// - Ignore-address one keeps current position, zero loads the frame address.
// - The 16-bit row position is shifted out during every frame.
// - A frame is eight control bits then sixteen address bits, select low.
// - Input sampled on rising clock edge, output changed on falling edge.
// - Pending interrupts clear when the next frame begins.
// - Control bits are decoded one by one into play, record, cue, stop and power actions.
module vsc_core
    import vsc_pkg::*;
#(
    parameter int WAKE_CYCLES = `VSC_WAKE_CYCLES,
    parameter logic [15:0] LAST_ROW = `VSC_LAST_ROW,
    parameter int STEP_CYCLES = `VSC_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic ss_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Interrupt pin, open drain
    output logic int_n_o,
    output logic int_n_oe,
    // Storage array side
    input wire logic end_of_message_marker,
    output logic [15:0] row_position,
    output logic playing,
    output logic recording,
    output logic cue_enable,
    output logic master_power,
    output logic ready
);
    logic ss_s;
    logic sclk_s;
    logic mosi_s;
    logic ss_d;
    logic sclk_d;
    logic frame_start;
    logic frame_end;
    logic rise;
    logic fall;
    logic [23:0] rx_word;
    logic [4:0] rx_count;
    logic miso_bit;
    logic memory_full_flag;
    logic marker_flag;
    logic step_due;
    logic [31:0] wake_cnt;
    logic [31:0] step_cnt;
    vsc_op_t op;
    logic cmd_valid;
    logic [7:0] cmd;
    logic [15:0] target_address;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    vsc_sync3 u_ss (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(ss_n), .dout(ss_s));
    vsc_sync3 u_sclk (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(sclk), .dout(sclk_s));
    vsc_sync3 u_mosi (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(mosi), .dout(mosi_s));

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ss_d <= 1'b1;
            sclk_d <= 1'b0;
        end else begin
            ss_d <= ss_s;
            sclk_d <= sclk_s;
        end
    end

    assign frame_start = ss_d && !ss_s;
    assign frame_end = !ss_d && ss_s;
    assign rise = !ss_s && sclk_s && !sclk_d;
    assign fall = !ss_s && !sclk_s && sclk_d;

    ////////////////////////////////////////////////////////////////////////////
    // Frame shifter; status word is flags then row position.
    vsc_shifter u_shift (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .frame_start(frame_start),
        .rise(rise),
        .fall(fall),
        .mosi_bit(mosi_s),
        .load_word({memory_full_flag, marker_flag, 6'h00, row_position}),
        .rx_word(rx_word),
        .rx_count(rx_count),
        .miso_bit(miso_bit)
    );

    assign miso = miso_bit;
    assign miso_oe = !ss_s;
    assign int_n_o = 1'b0;
    assign int_n_oe = memory_full_flag || marker_flag;

    // Only a frame of exactly the full bit count is acted upon.
    assign cmd_valid = frame_end && rx_count == 5'(`VSC_FRAME_BITS);
    assign cmd = rx_word[`VSC_FRAME_BITS-1:`VSC_ADDR_BITS];
    assign target_address = rx_word[`VSC_ADDR_BITS-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Power control and wake delay.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            master_power <= 1'b0;
            wake_cnt <= 32'h0000_0000;
            ready <= 1'b0;
        end else if (cmd_valid && !cmd[`VSC_BIT_POWER] && !cmd[`VSC_BIT_GO]) begin
            master_power <= 1'b0;
            ready <= 1'b0;
        end else if (cmd_valid && cmd[`VSC_BIT_POWER] && !master_power) begin
            master_power <= 1'b1;
            wake_cnt <= 32'(WAKE_CYCLES);
            ready <= 1'b0;
        end else if (master_power && !ready) begin
            if (wake_cnt <= 32'h0000_0001) begin
                ready <= 1'b1;
            end else begin
                wake_cnt <= wake_cnt - 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation control, row pointer and interrupt flags.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            op <= VSC_IDLE;
            cue_enable <= 1'b0;
            row_position <= 16'h0000;
            step_cnt <= 32'h0000_0000;
        end else if (cmd_valid && cmd[`VSC_BIT_GO] && ready && op == VSC_IDLE) begin
            // 11xxx = play family, 10xxx = record family (cue bit ignored).
            if (!cmd[`VSC_BIT_IGNADDR]) begin
                row_position <= target_address;
            end
            if (cmd[`VSC_BIT_DIR]) begin
                op <= VSC_PLAY;
                cue_enable <= cmd[`VSC_BIT_CUE];
            end else begin
                op <= VSC_REC;
                cue_enable <= 1'b0;
            end
            step_cnt <= 32'(STEP_CYCLES);
        end else if (cmd_valid && !cmd[`VSC_BIT_GO]) begin
            op <= VSC_IDLE;
            cue_enable <= 1'b0;
        end else begin
            case (op)
                VSC_PLAY: begin
                    if (end_of_message_marker) begin
                        op <= VSC_IDLE;
                        cue_enable <= 1'b0;
                    end else if (step_cnt <= 32'h0000_0001 || cue_enable) begin
                        step_cnt <= 32'(STEP_CYCLES);
                        if (row_position == LAST_ROW) begin
                            op <= VSC_IDLE;
                            cue_enable <= 1'b0;
                        end else begin
                            row_position <= row_position + 16'h0001;
                        end
                    end else begin
                        step_cnt <= step_cnt - 32'h0000_0001;
                    end
                end
                VSC_REC: begin
                    if (step_cnt <= 32'h0000_0001) begin
                        step_cnt <= 32'(STEP_CYCLES);
                        if (row_position == LAST_ROW) begin
                            op <= VSC_IDLE;
                        end else begin
                            row_position <= row_position + 16'h0001;
                        end
                    end else begin
                        step_cnt <= step_cnt - 32'h0000_0001;
                    end
                end
                default: begin
                    op <= VSC_IDLE;
                end
            endcase
        end
    end

    // A row step is due on the slow row timer, or on every cycle while cueing.
    assign step_due = step_cnt <= 32'h0000_0001 || (op == VSC_PLAY && cue_enable);

    // Set wins over the clear at frame start.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            marker_flag <= 1'b0;
            memory_full_flag <= 1'b0;
        end else begin
            if (op == VSC_PLAY && end_of_message_marker) begin
                marker_flag <= 1'b1;
            end else if (frame_start) begin
                marker_flag <= 1'b0;
            end
            // Cueing can run off the array end too, so it must raise overflow as well.
            if (op != VSC_IDLE && row_position == LAST_ROW && step_due
                    && !(op == VSC_PLAY && end_of_message_marker)) begin
                memory_full_flag <= 1'b1;
            end else if (frame_start) begin
                memory_full_flag <= 1'b0;
            end
        end
    end

    assign playing = op == VSC_PLAY;
    assign recording = op == VSC_REC;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_wake_arm;
        cmd_valid && cmd[`VSC_BIT_POWER] && !master_power;
    endsequence

    chk_wake_not_early: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_wake_arm |=> !ready [*8])
        else $error("ready rose too soon after power-on");
    chk_marker_halts: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (op == VSC_PLAY && end_of_message_marker && !cmd_valid) |=> (op == VSC_IDLE && marker_flag))
        else $error("playback did not stop at end of message");
    chk_stop_cmd: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cmd_valid && !cmd[`VSC_BIT_GO]) |=> op == VSC_IDLE)
        else $error("stop command ignored");
    chk_dir_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cmd_valid && cmd[`VSC_BIT_GO] && ready && op == VSC_IDLE)
        |=> (playing == $past(cmd[`VSC_BIT_DIR])) && (playing != recording))
        else $error("wrong operation direction");
    chk_addr_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cmd_valid && cmd[`VSC_BIT_GO] && ready && op == VSC_IDLE && !cmd[`VSC_BIT_IGNADDR])
        |=> row_position == $past(target_address))
        else $error("target address not loaded");
    chk_cue_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (op != VSC_IDLE && !cmd_valid) |=> !$rose(cue_enable))
        else $error("cueing enabled mid-operation");
    chk_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (frame_start && op == VSC_IDLE) |=> !marker_flag && !memory_full_flag)
        else $error("interrupt not cleared at frame start");
    chk_short_frame: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (frame_end && rx_count != 5'(`VSC_FRAME_BITS) && op == VSC_IDLE) |=> op == VSC_IDLE)
        else $error("short frame acted upon");
    chk_power_down: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cmd_valid && !cmd[`VSC_BIT_POWER] && !cmd[`VSC_BIT_GO]) |=> !master_power && !ready)
        else $error("power-down not honoured");

    // Recording reaches the last row with its row timer expiring.
    sequence s_row_end;
        op == VSC_REC && row_position == LAST_ROW && step_due && !cmd_valid;
    endsequence

    chk_overflow_halts: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_row_end |=> !recording && memory_full_flag)
        else $error("recording did not stop at memory end");
    chk_status_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        frame_start |=> miso == $past(memory_full_flag))
        else $error("status word not loaded at frame start");
    chk_ready_powered: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ready |-> master_power)
        else $error("ready while powered down");
    chk_go_refused: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cmd_valid && cmd[`VSC_BIT_GO] && !ready && op == VSC_IDLE) |=> op == VSC_IDLE)
        else $error("operation started before wake delay");
    chk_cue_play_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cue_enable |-> playing)
        else $error("cueing active outside playback");
    chk_miso_fall: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!frame_start && !fall) |=> $stable(miso))
        else $error("output bit moved off a falling edge");
    chk_frame_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        frame_start |=> rx_count == 5'h00)
        else $error("bit count not cleared at frame start");
endmodule

// File: vsc_host_model.sv
// Behavioural serial master that stands in for the host microcontroller.
// Assumes the device samples on rising link-clock edges and shifts out on falling ones.
module vsc_host_model (
    // Link pins
    output logic ss_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ss_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shifts nbits of word out MSB first while collecting the status word.
    // A count below 24 makes a deliberately short frame.
    task automatic frame(input logic [23:0] word, input int nbits, output logic [23:0] rx);
        rx = 24'h000000;
        ss_n = 1'b0;
        mosi = word[23];
        #125;
        for (int i = 23; i > 23 - nbits; i--) begin
            sclk = 1'b1;
            rx[i] = miso;
            #62.5;
            sclk = 1'b0;
            #1;
            mosi = (i > 0) ? word[i - 1] : ~word[0];
            #61.5;
        end
        ss_n = 1'b1;
        // The line is not held after the frame, so it shows a changed level.
        mosi = ~mosi;
    endtask
endmodule

// File: tb.sv
// Self-checking bench for the voice store serial control block.
// Assumes the host model drives the link and the bench models the storage array marker.
`define VSC_TB_CHK(what, exp, got) \
    begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // Short counts so the whole run stays brief.
    localparam int WAKE = 1000;
    localparam int STEP = 100;
    localparam logic [15:0] LAST = 16'h0010;

    logic clk_sys;
    logic sys_rst;
    logic ss_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic int_n_o;
    logic int_n_oe;
    logic int_n;
    logic marker;
    logic [15:0] row_position;
    logic [15:0] marker_row;
    logic playing;
    logic recording;
    logic cue_enable;
    logic master_power;
    logic ready;
    logic [23:0] rx;
    int err_count;
    int n_checks;

    // The interrupt line has a pull-up on the board.
    assign int_n = int_n_oe ? int_n_o : 1'b1;
    assign marker = playing && (row_position == marker_row);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    vsc_core #(.WAKE_CYCLES(WAKE), .LAST_ROW(LAST), .STEP_CYCLES(STEP)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .end_of_message_marker(marker), .row_position(row_position), .playing(playing),
        .recording(recording), .cue_enable(cue_enable), .master_power(master_power),
        .ready(ready)
    );

    vsc_host_model host_u (.ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One full frame, then time for the command to take effect.
    task automatic send(input logic [7:0] ctrl, input logic [15:0] addr);
        host_u.frame({ctrl, addr}, 24, rx);
        repeat (12) @(posedge clk_sys);
        #1;
    endtask

    // Waits, bounded, for ready high or for the device to go idle.
    task automatic wait_for(input bit want_ready);
        int k;
        for (k = 0; k < 5000; k++) begin
            if (want_ready ? (ready === 1'b1) : (playing === 1'b0 && recording === 1'b0)) begin
                break;
            end
            @(posedge clk_sys);
            #1;
        end
        if (k == 5000) begin
            err_count++;
            $display("[FAIL] wait expected %0d seen timeout", want_ready);
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        marker_row = 16'h0008;
        err_count = 0;
        n_checks = 0;
        repeat (10) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        `VSC_TB_CHK("power after reset", 1'b0, master_power)
        `VSC_TB_CHK("int after reset", 1'b1, int_n)
        `VSC_TB_CHK("miso idle", 1'b0, miso_oe)
        $display("test reset done");

        send(8'h20, 16'h0000);
        `VSC_TB_CHK("power on", 1'b1, master_power)
        `VSC_TB_CHK("ready early", 1'b0, ready)
        send(8'hE0, 16'h0004);
        `VSC_TB_CHK("play before ready", 1'b0, playing)
        wait_for(1'b1);
        send(8'hE0, 16'h0004);
        `VSC_TB_CHK("play started", 1'b1, playing)
        `VSC_TB_CHK("no record", 1'b0, recording)
        `VSC_TB_CHK("loaded row", 16'h0004, row_position)
        `VSC_TB_CHK("no cue", 1'b0, cue_enable)
        wait_for(1'b0);
        `VSC_TB_CHK("row at marker", 16'h0008, row_position)
        `VSC_TB_CHK("marker int", 1'b0, int_n)
        $display("test play done");

        send(8'h30, 16'h0000);
        `VSC_TB_CHK("marker status", 1'b1, rx[22])
        `VSC_TB_CHK("row status", 16'h0008, rx[15:0])
        `VSC_TB_CHK("int cleared", 1'b1, int_n)
        marker_row = 16'h000C;
        // Cueing from the current row must reach the next marker far faster than one row time.
        send(8'hF8, 16'h0020);
        `VSC_TB_CHK("cue row", 16'h000C, row_position)
        wait_for(1'b0);
        `VSC_TB_CHK("cue int", 1'b0, int_n)
        $display("test cue done");

        host_u.frame({8'hE0, 16'h0000}, 12, rx);
        repeat (12) @(posedge clk_sys);
        #1;
        `VSC_TB_CHK("short frame", 1'b0, playing)
        marker_row = 16'h0040;
        send(8'hE0, 16'h0000);
        `VSC_TB_CHK("play again", 1'b1, playing)
        send(8'hF8, 16'h0000);
        `VSC_TB_CHK("late cue", 1'b0, cue_enable)
        send(8'h30, 16'h0000);
        `VSC_TB_CHK("stopped", 1'b0, playing)
        $display("test stop done");

        send(8'h20, 16'h0000);
        send(8'hA0, 16'h000C);
        `VSC_TB_CHK("recording", 1'b1, recording)
        wait_for(1'b0);
        `VSC_TB_CHK("record end row", LAST, row_position)
        `VSC_TB_CHK("overflow int", 1'b0, int_n)
        send(8'h10, 16'h0000);
        `VSC_TB_CHK("overflow status", 1'b1, rx[23])
        `VSC_TB_CHK("power down", 1'b0, master_power)
        $display("test record done");
        end_of_test();
    end
endmodule
